// >>> verilog/ifs_status_regs.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module ifs_status_regs #(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  RST,
    input  wire logic                  CE,
    // apb slave
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [AW-1:0]         PADDR,
    input  wire logic [31:0]           PWDATA,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    // events from framing and memory logic
    input  wire ifs_pkg::ifs_event_type EVENTS,
    input  wire logic [6:0]            MAIN_EVENTS,
    input  wire ifs_pkg::ifs_buf_type   BUF_IN,
    // interrupt line
    output logic                       IRQ
);
    initial begin
        if (AW < 8) $error("address width must be at least 8");
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire       setup    = PSEL && !PENABLE;           // setup cycle
    wire       access   = PSEL && PENABLE && PREADY;  // completing cycle
    wire [AW+9:0] addr_wide = {10'h000, PADDR};         // zero-extended byte address
    wire [7:0] word_idx = addr_wide[9:2];               // register index
    wire       aligned  = (PADDR[1:0] == ifs_pkg::ADDR_LSB_ZERO);
    wire       hit_amask = aligned && (word_idx == ifs_pkg::IDX_AUX_MASK);
    wire       hit_mmask = aligned && (word_idx == ifs_pkg::IDX_MAIN_MASK);
    wire       hit_main  = aligned && (word_idx == ifs_pkg::IDX_MAIN_IRQ);
    wire       hit_aux   = aligned && (word_idx == ifs_pkg::IDX_AUX_EVENTS);
    wire       hit_fill  = aligned && (word_idx == ifs_pkg::IDX_FILL_COUNT);
    wire       hit_err   = aligned && (word_idx == ifs_pkg::IDX_BUF_ERROR);
    wire       hit_cmd   = aligned && (word_idx == ifs_pkg::IDX_COMMAND);
    wire       hit_any   = hit_amask || hit_mmask || hit_main || hit_aux
                           || hit_fill || hit_err || hit_cmd;
    wire       rd_main   = access && !PWRITE && hit_main;  // main read
    wire       rd_aux    = access && !PWRITE && hit_aux;   // aux read
    wire       wr_cmd    = access && PWRITE && hit_cmd;    // command write

    // ----------------------------------------------------------------
    // commands: restore defaults and buffer clear
    // ----------------------------------------------------------------
    wire set_default = wr_cmd && PWDATA[ifs_pkg::CMD_DEFAULTS];  // soft reset
    wire buf_clear   = wr_cmd && PWDATA[ifs_pkg::CMD_CLEAR];     // buffer clear

    // ----------------------------------------------------------------
    // mask registers
    // ----------------------------------------------------------------
    logic [7:0] aux_mask_q;   // auxiliary mask
    logic [7:0] main_mask_q;  // main mask

    // masks written by software, restored on defaults
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            aux_mask_q  <= ifs_pkg::RST_ZERO;
            main_mask_q <= ifs_pkg::RST_MAIN_MASK;
        end else if (CE) begin
            if (set_default) begin
                aux_mask_q  <= ifs_pkg::RST_ZERO;
                main_mask_q <= ifs_pkg::RST_MAIN_MASK;
            end else if (access && PWRITE && hit_amask) begin
                aux_mask_q <= PWDATA[7:0];
            end else if (access && PWRITE && hit_mmask) begin
                main_mask_q <= PWDATA[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // buffer fill counter
    // ----------------------------------------------------------------
    logic [5:0] fill_count;  // unread bytes
    wire        buf_unf;     // pop from empty buffer
    wire        buf_ovr;     // push into full buffer

    ifs_fill #(
        .CW    (6),
        .DEPTH (ifs_pkg::BUF_DEPTH)
    ) u_fill (
        .clk       (MCLK),
        .rst       (RST),
        .ce        (CE),
        .clr       (set_default || buf_clear),
        .push      (BUF_IN.push),
        .pop       (BUF_IN.pop),
        .count_q   (fill_count),
        .underflow (buf_unf),
        .overflow  (buf_ovr)
    );

    // ----------------------------------------------------------------
    // auxiliary event sources
    // ----------------------------------------------------------------
    wire        fault_frame = EVENTS.rx_framing
                              || (BUF_IN.push && BUF_IN.last_no_parity);
    wire        nvm_host    = EVENTS.nvm_from_host;
    wire [7:0]  aux_set;
    assign aux_set[ifs_pkg::AUX_DESELECT]  = EVENTS.deselect;
    assign aux_set[ifs_pkg::AUX_FRAMING]   = fault_frame;
    assign aux_set[ifs_pkg::AUX_PARITY]    = EVENTS.rx_parity;
    assign aux_set[ifs_pkg::AUX_CHECKSUM]  = EVENTS.rx_checksum;
    assign aux_set[ifs_pkg::AUX_BUFFER]    = buf_unf || buf_ovr;
    assign aux_set[ifs_pkg::AUX_NVM_DONE]  = EVENTS.nvm_done && nvm_host;
    assign aux_set[ifs_pkg::AUX_NVM_FAULT] = EVENTS.nvm_fault && nvm_host;
    assign aux_set[ifs_pkg::AUX_PREEMPT]   = EVENTS.nvm_preempt;

    // ----------------------------------------------------------------
    // sticky auxiliary flags, cleared by their own read
    // ----------------------------------------------------------------
    logic [7:0] aux_flags;  // aux_event_flags

    ifs_sticky #(
        .WIDTH (8)
    ) u_aux (
        .clk      (MCLK),
        .rst      (RST),
        .ce       (CE),
        .soft_clr (set_default),
        .set      (aux_set),
        .rd_clr   (rd_aux),
        .flags_q  (aux_flags)
    );

    // ----------------------------------------------------------------
    // sticky main flags bits 7..1, cleared by main read
    // ----------------------------------------------------------------
    logic [6:0] main_flags;  // main bits 7..1

    ifs_sticky #(
        .WIDTH (7)
    ) u_main (
        .clk      (MCLK),
        .rst      (RST),
        .ce       (CE),
        .soft_clr (set_default),
        .set      (MAIN_EVENTS),
        .rd_clr   (rd_main),
        .flags_q  (main_flags)
    );

    // summary bit follows pending unmasked aux events, untouched by main read
    wire        aux_pending = |(aux_flags & ~aux_mask_q);
    wire [7:0]  main_view   = {main_flags, aux_pending};

    // ----------------------------------------------------------------
    // second buffer status register
    // ----------------------------------------------------------------
    logic       unf_q;      // underflow seen
    logic       ovr_q;      // overflow seen
    logic       part_q;     // last byte incomplete
    logic [2:0] bits_q;     // valid bits in last byte
    logic       nopar_q;    // last byte missed parity
    wire        st2_clr = set_default || buf_clear;

    // cause flags hold until clear, last byte info tracks each push
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            unf_q   <= 1'b0;
            ovr_q   <= 1'b0;
            part_q  <= 1'b0;
            bits_q  <= 3'h0;
            nopar_q <= 1'b0;
        end else if (CE) begin
            if (st2_clr) begin
                unf_q   <= 1'b0;
                ovr_q   <= 1'b0;
                part_q  <= 1'b0;
                bits_q  <= 3'h0;
                nopar_q <= 1'b0;
            end else begin
                unf_q <= unf_q || buf_unf;
                ovr_q <= ovr_q || buf_ovr;
                if (BUF_IN.push) begin
                    part_q  <= BUF_IN.last_partial;
                    bits_q  <= BUF_IN.last_partial ? BUF_IN.last_bits : 3'h0;
                    nopar_q <= BUF_IN.last_no_parity;
                end
            end
        end
    end

    wire [7:0] st2_view = {1'b0, unf_q, ovr_q, part_q, bits_q, nopar_q};
    wire [7:0] st1_view = {2'h0, fill_count};

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [7:0] rd_byte = hit_amask ? aux_mask_q  :
                         hit_mmask ? main_mask_q :
                         hit_main  ? main_view   :
                         hit_aux   ? aux_flags   :
                         hit_fill  ? st1_view    :
                         hit_err   ? st2_view    : ifs_pkg::RST_ZERO;

    // ----------------------------------------------------------------
    // apb answer: ready in the cycle after setup
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY  <= setup;
            PSLVERR <= setup && !hit_any;
            if (setup && !PWRITE) begin
                PRDATA <= {24'h00_0000, rd_byte};
            end else if (access) begin
                PRDATA <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt output
    // ----------------------------------------------------------------
    wire irq_d = |(main_view & ~main_mask_q);

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            IRQ <= irq_d;
        end
    end
endmodule

// >>> verilog/ifs_pkg.sv
package ifs_pkg;
    // ------------------------------------------------------------------
    // register word indices (printed offsets not all multiples of four)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_AUX_MASK   = 8'h09;  // auxiliary mask index
    localparam logic [7:0] IDX_MAIN_IRQ   = 8'h0A;  // main interrupt index
    localparam logic [7:0] IDX_AUX_EVENTS = 8'h0B;  // aux_event_flags index
    localparam logic [7:0] IDX_FILL_COUNT = 8'h0C;  // buffer_fill_count index
    localparam logic [7:0] IDX_BUF_ERROR  = 8'h0D;  // buffer_error_status index
    localparam logic [7:0] IDX_MAIN_MASK  = 8'h08;  // main mask index
    localparam logic [7:0] IDX_COMMAND    = 8'h20;  // command register index
    localparam logic [1:0] ADDR_LSB_ZERO  = 2'h0;   // word alignment bits

    // ------------------------------------------------------------------
    // aux_event_flags bit positions
    // ------------------------------------------------------------------
    localparam int AUX_DESELECT  = 7;  // deselect received
    localparam int AUX_FRAMING   = 6;  // framing_fault_flag
    localparam int AUX_PARITY    = 5;  // parity_fault_flag
    localparam int AUX_CHECKSUM  = 4;  // checksum_fault_flag
    localparam int AUX_BUFFER    = 3;  // buffer_fault_flag
    localparam int AUX_NVM_DONE  = 2;  // programming done
    localparam int AUX_NVM_FAULT = 1;  // nvm_program_fault_flag
    localparam int AUX_PREEMPT   = 0;  // nvm_access_preempted_flag

    // ------------------------------------------------------------------
    // main interrupt and buffer status fields
    // ------------------------------------------------------------------
    localparam int MAIN_AUX_SUMMARY = 0;  // summary of auxiliary events
    localparam int ST2_UNDERFLOW    = 6;  // underflow bit
    localparam int ST2_OVERFLOW     = 5;  // overflow bit
    localparam int ST2_INCOMPLETE   = 4;  // last byte incomplete
    localparam int ST2_BITCNT_LSB   = 1;  // last_byte_bitcount_lsb
    localparam int ST2_NO_PARITY    = 0;  // last_byte_no_parity
    localparam int CMD_DEFAULTS     = 0;  // command: restore defaults
    localparam int CMD_CLEAR        = 1;  // command: buffer clear

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ZERO      = 8'h00;  // cleared registers
    localparam logic [7:0] RST_MAIN_MASK = 8'hC0;  // main mask default
    localparam logic [5:0] BUF_DEPTH     = 6'h20;  // 32 byte buffer

    // ------------------------------------------------------------------
    // event inputs from the framing and memory logic
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       deselect;       // deselect command from reader
        logic       rx_framing;     // receive framing error
        logic       rx_parity;      // parity error on stored frame
        logic       rx_checksum;    // checksum error on stored frame
        logic       nvm_done;       // programming finished ok
        logic       nvm_fault;      // protected or missing address
        logic       nvm_from_host;  // programming came from host port
        logic       nvm_preempt;    // host access cut by card interface
    } ifs_event_type;

    typedef struct packed {
        logic       push;           // byte written into buffer
        logic       pop;            // byte read out by host
        logic       last_partial;   // last pushed byte incomplete
        logic [2:0] last_bits;      // valid bits of partial byte
        logic       last_no_parity; // last byte missed parity
    } ifs_buf_type;
endpackage

// >>> verilog/ifs_sticky.sv
`timescale 1ns/1ps
// sticky flag bank: set wins over read clear
module ifs_sticky #(
    parameter int WIDTH = 8
) (
    // clocking
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // control
    input  wire logic             soft_clr,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic             rd_clr,
    // state
    output logic      [WIDTH-1:0] flags_q
);
    initial begin
        if (WIDTH < 1) $error("width must be positive");
    end

    // -----------------------------------------------------------------
    // per bit flag
    // -----------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        // set beats read clear, soft clear beats all
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                flags_q[i] <= 1'b0;
            end else if (ce) begin
                if (soft_clr) begin
                    flags_q[i] <= 1'b0;
                end else if (set[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (rd_clr) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    end
endmodule

// >>> verilog/ifs_fill.sv
`timescale 1ns/1ps
// unread byte counter with underflow and overflow detection
module ifs_fill #(
    parameter int         CW    = 6,
    parameter logic [5:0] DEPTH = ifs_pkg::BUF_DEPTH
) (
    // clocking
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          clr,
    // buffer traffic
    input  wire logic          push,
    input  wire logic          pop,
    // results
    output logic      [CW-1:0] count_q,
    output logic               underflow,
    output logic               overflow
);
    initial begin
        if (CW != 6) $error("count width must be 6");
    end

    wire empty = (count_q == '0);       // nothing to read
    wire full  = (count_q == DEPTH);    // no room left
    assign underflow = pop && !push && empty;
    assign overflow  = push && !pop && full;

    // count follows traffic, saturating at the ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (ce) begin
            if (clr) begin
                count_q <= '0;
            end else if (push && !pop && !full) begin
                count_q <= count_q + CW'(1);
            end else if (pop && !push && !empty) begin
                count_q <= count_q - CW'(1);
            end
        end
    end
endmodule

// >>> verification/ifs_status_regs_sva.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// port-level checks of the status register block
// ------------------------------------------------------------------
module ifs_status_regs_sva #(
    parameter int AW = 8
) (
    // clock and reset
    input wire logic                   MCLK,
    input wire logic                   RST,
    input wire logic                   CE,
    // apb slave
    input wire logic                   PSEL,
    input wire logic                   PENABLE,
    input wire logic                   PWRITE,
    input wire logic [AW-1:0]          PADDR,
    input wire logic [31:0]            PWDATA,
    input wire logic [31:0]            PRDATA,
    input wire logic                   PREADY,
    input wire logic                   PSLVERR,
    // events and interrupt
    input wire ifs_pkg::ifs_event_type EVENTS,
    input wire logic [6:0]             MAIN_EVENTS,
    input wire ifs_pkg::ifs_buf_type   BUF_IN,
    input wire logic                   IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // transfer phases and event activity
    wire logic setup  = PSEL && !PENABLE && CE;
    wire logic acc    = PSEL && PENABLE && PREADY && CE;
    wire logic ev_any = (EVENTS != '0) || (MAIN_EVENTS != '0) || BUF_IN.push || BUF_IN.pop;

    // aux read taken while nothing new arrives
    sequence aux_read_taken;
        acc && !PWRITE && PADDR == 8'h2C && !ev_any;
    endsequence
    // quiet gap, then the next aux read is set up
    sequence aux_reread;
        !ev_any ##1 (setup && !PWRITE && PADDR == 8'h2C && !ev_any);
    endsequence

    ready_timing_a: assert property (setup |=> PREADY)
        else $error("ready missing after setup");
    ready_pulse_a: assert property (PREADY && CE |=> !PREADY)
        else $error("ready held longer than one cycle");
    err_with_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    unaligned_err_a: assert property (setup && !PWRITE && PADDR[1:0] != 2'h0
        |=> PREADY && PSLVERR && PRDATA == 32'h0)
        else $error("unaligned read not refused");
    mapped_ok_a: assert property (setup && PADDR == 8'h2C |=> PREADY && !PSLVERR)
        else $error("mapped access refused");
    upper_zero_a: assert property (PREADY && !PSLVERR |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    aux_clear_a: assert property (aux_read_taken ##1 aux_reread |=> PRDATA[7:0] == 8'h00)
        else $error("aux flags survive a read");
    fill_range_a: assert property (setup && !PWRITE && PADDR == 8'h30 |=> PRDATA[7:0] <= 8'h20)
        else $error("unread count out of range");
    irq_cause_a: assert property ($rose(IRQ) |-> $past(ev_any) || $past(ev_any, 2)
        || $past(acc && PWRITE) || $past(acc && PWRITE, 2))
        else $error("interrupt raised without cause");
    irq_release_a: assert property ($fell(IRQ) |-> $past(acc) || $past(acc, 2))
        else $error("interrupt dropped without host access");
endmodule

bind ifs_status_regs ifs_status_regs_sva #(.AW(AW)) u_sva (
    .MCLK(MCLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EVENTS(EVENTS), .MAIN_EVENTS(MAIN_EVENTS), .BUF_IN(BUF_IN), .IRQ(IRQ)
);

// >>> verification/ifs_source_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// framing and memory logic stand-in: one-cycle event pulses
// ------------------------------------------------------------------
module ifs_source_model (
    // clock
    input  wire logic              clk,
    // pulses toward the register block
    output ifs_pkg::ifs_event_type evt,
    output logic [6:0]             main_evt,
    output ifs_pkg::ifs_buf_type   buf_in
);
    // idle level: nothing pending
    initial begin
        evt      = '0;
        main_evt = '0;
        buf_in   = '0;
    end

    // pulse launched after an edge, withdrawn after the next
    task automatic pulse(input logic [7:0] e, input logic [6:0] m, input logic [6:0] b);
        @(posedge clk);
        evt      <= ifs_pkg::ifs_event_type'(e);
        main_evt <= m;
        buf_in   <= ifs_pkg::ifs_buf_type'(b);
        @(posedge clk);
        evt      <= '0;
        main_evt <= '0;
        buf_in   <= '0;
    endtask
endmodule

// >>> verification/test_irq_and_fifo_status_regs.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// bench: apb host reads and writes, event source drives pulses
// ------------------------------------------------------------------
module test_irq_and_fifo_status_regs;
    logic        MCLK    = 1'b0;   // 20 MHz clock
    logic        RST     = 1'b1;   // async reset
    logic        PSEL    = 1'b0;   // apb select
    logic        PENABLE = 1'b0;   // apb access phase
    logic        PWRITE  = 1'b0;   // apb direction
    logic [7:0]  PADDR   = 8'h00;  // byte address
    logic [31:0] PWDATA  = 32'h0;  // write data
    logic [31:0] PRDATA;           // read data
    logic        PREADY;           // slave answer
    logic        PSLVERR;          // slave refusal
    logic        IRQ;              // interrupt line
    logic [31:0] rdata;            // data of last transfer
    logic        rerr;             // refusal of last transfer
    int          error_cnt   = 0;  // mismatches
    int          comparisons = 0;  // checks made
    int          cycles      = 0;  // watchdog count
    ifs_pkg::ifs_event_type evt;
    logic [6:0]             main_evt;
    ifs_pkg::ifs_buf_type   buf_in;
    // event pattern and the aux bit it should raise
    logic [7:0] ev_tab  [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0A, 8'h06, 8'h01};
    logic [7:0] aux_tab [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};

    // clock generator
    initial begin
        forever #25 MCLK = ~MCLK;
    end

    ifs_source_model src (.clk(MCLK), .evt(evt), .main_evt(main_evt), .buf_in(buf_in));
    ifs_status_regs dut (
        .MCLK(MCLK), .RST(RST), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .EVENTS(evt), .MAIN_EVENTS(main_evt), .BUF_IN(buf_in), .IRQ(IRQ)
    );

    // verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        rdata = PRDATA;
        rerr  = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // read and compare
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rdata, e);
    endtask

    // interrupt level once the flag has landed
    task automatic irq_chk(input logic e);
        @(posedge MCLK);
        #1;
        check({31'h0, IRQ}, {31'h0, e});
    endtask

    // watchdog against a hung handshake
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    // main sequence
    initial begin
        repeat (12) @(posedge MCLK);
        RST <= 1'b0;
        rd_chk(8'h2C, 32'h00);
        rd_chk(8'h28, 32'h00);
        rd_chk(8'h30, 32'h00);
        rd_chk(8'h34, 32'h00);
        // each aux event except buffer fault: summary, flag, clear on read
        for (int i = 0; i < 7; i++) begin
            src.pulse(ev_tab[i], 7'h00, 7'h00);
            irq_chk(1'b1);
            rd_chk(8'h28, 32'h01);
            rd_chk(8'h2C, {24'h0, aux_tab[i]});
            rd_chk(8'h2C, 32'h00);
            rd_chk(8'h28, 32'h00);
            irq_chk(1'b0);
        end
        // programming done not from the host port
        src.pulse(8'h08, 7'h00, 7'h00);
        rd_chk(8'h2C, 32'h00);
        // main read keeps bit0 until aux is read
        src.pulse(8'h80, 7'h04, 7'h00);
        rd_chk(8'h28, 32'h09);
        rd_chk(8'h28, 32'h01);
        rd_chk(8'h2C, 32'h80);
        rd_chk(8'h28, 32'h00);
        // masked aux event stays silent
        apb(1'b1, 8'h24, 32'h80);
        src.pulse(8'h80, 7'h00, 7'h00);
        irq_chk(1'b0);
        rd_chk(8'h28, 32'h00);
        rd_chk(8'h2C, 32'h80);
        apb(1'b1, 8'h24, 32'h00);
        // restore defaults wipes pending flags
        src.pulse(8'h40, 7'h04, 7'h00);
        apb(1'b1, 8'h80, 32'h01);
        rd_chk(8'h2C, 32'h00);
        rd_chk(8'h28, 32'h00);
        // parity error with data still stored
        src.pulse(8'h20, 7'h00, 7'h40);
        rd_chk(8'h30, 32'h01);
        rd_chk(8'h2C, 32'h20);
        // fill to the top, then overflow
        repeat (31) src.pulse(8'h00, 7'h00, 7'h40);
        rd_chk(8'h30, 32'h20);
        src.pulse(8'h00, 7'h00, 7'h40);
        rd_chk(8'h30, 32'h20);
        rd_chk(8'h34, 32'h20);
        rd_chk(8'h2C, 32'h08);
        apb(1'b1, 8'h80, 32'h02);
        rd_chk(8'h30, 32'h00);
        rd_chk(8'h34, 32'h00);
        // read from an empty buffer
        src.pulse(8'h00, 7'h00, 7'h20);
        rd_chk(8'h34, 32'h40);
        rd_chk(8'h2C, 32'h08);
        apb(1'b1, 8'h80, 32'h02);
        // incomplete last byte, three bits, parity missing
        src.pulse(8'h00, 7'h00, 7'h57);
        rd_chk(8'h34, 32'h17);
        rd_chk(8'h2C, 32'h40);
        rd_chk(8'h30, 32'h01);
        // unmapped and unaligned places are refused
        rd_chk(8'h3C, 32'h00);
        check({31'h0, rerr}, 32'h1);
        rd_chk(8'h2D, 32'h00);
        check({31'h0, rerr}, 32'h1);
        close_out();
    end
endmodule
